// File: err_queue_pkg.sv
// Package for the command error queue: error codes, message indices, queue sizing, carriers.
// Assumes a single synchronous clock domain; codes are signed 16-bit values.
package err_queue_pkg;

    localparam int          QUEUE_DEPTH   = 10;
    localparam int          PTR_W         = 4;
    localparam int          CNT_W         = 4;
    localparam int          CODE_W        = 16;
    localparam int          MSG_W         = 6;
    localparam int          TEXT_MAX      = 80;
    localparam int          HEADER_MAX    = 12;
    localparam int          SUFFIX_MAX    = 12;
    localparam int          STRING_MAX    = 12;
    localparam int          MANTISSA_MAX  = 255;
    localparam int          LEN_W         = 9;
    localparam int          EVT_N         = 17;
    localparam int          BEEP_NS       = 100;
    localparam int          CLK_NS        = 40;
    localparam int          BEEP_CYC      = (BEEP_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [PTR_W-1:0]  PTR_LAST = 4'(QUEUE_DEPTH - 1);
    localparam logic [CNT_W-1:0]  CNT_FULL = 4'(QUEUE_DEPTH);

    localparam logic signed [CODE_W-1:0] CODE_NONE        = 16'sh0000;
    localparam logic signed [CODE_W-1:0] CODE_GET         = -16'sh0069;
    localparam logic signed [CODE_W-1:0] CODE_PARAM_EXTRA = -16'sh006C;
    localparam logic signed [CODE_W-1:0] CODE_PARAM_MISS  = -16'sh006D;
    localparam logic signed [CODE_W-1:0] CODE_HDR_LONG    = -16'sh0070;
    localparam logic signed [CODE_W-1:0] CODE_DIGITS      = -16'sh007C;
    localparam logic signed [CODE_W-1:0] CODE_SUFFIX_LONG = -16'sh0086;
    localparam logic signed [CODE_W-1:0] CODE_TRIG_IGN    = -16'sh00D3;
    localparam logic signed [CODE_W-1:0] CODE_INIT_IGN    = -16'sh00D5;
    localparam logic signed [CODE_W-1:0] CODE_TRIG_DEAD   = -16'sh00D6;
    localparam logic signed [CODE_W-1:0] CODE_SETTINGS    = -16'sh00DD;
    localparam logic signed [CODE_W-1:0] CODE_TOO_MUCH    = -16'sh00DF;
    localparam logic signed [CODE_W-1:0] CODE_STALE       = -16'sh00E6;
    localparam logic signed [CODE_W-1:0] CODE_OVERFLOW    = -16'sh015E;
    localparam logic signed [CODE_W-1:0] CODE_Q_INTR      = -16'sh019A;
    localparam logic signed [CODE_W-1:0] CODE_Q_UNTERM    = -16'sh01A4;
    localparam logic signed [CODE_W-1:0] CODE_Q_DEAD      = -16'sh01AE;
    localparam logic signed [CODE_W-1:0] CODE_Q_INDEF     = -16'sh01B8;

    typedef enum logic [MSG_W-1:0] {
        MSG_NONE        = 6'h00,
        MSG_GET         = 6'h01,
        MSG_PARAM_EXTRA = 6'h02,
        MSG_PARAM_MISS  = 6'h03,
        MSG_HDR_LONG    = 6'h04,
        MSG_DIGITS      = 6'h05,
        MSG_SUFFIX_LONG = 6'h06,
        MSG_TRIG_IGN    = 6'h07,
        MSG_INIT_IGN    = 6'h08,
        MSG_TRIG_DEAD   = 6'h09,
        MSG_SETTINGS    = 6'h0A,
        MSG_TOO_MUCH    = 6'h0B,
        MSG_STALE       = 6'h0C,
        MSG_OVERFLOW    = 6'h0D,
        MSG_Q_INTR      = 6'h0E,
        MSG_Q_UNTERM    = 6'h0F,
        MSG_Q_DEAD      = 6'h10,
        MSG_Q_INDEF     = 6'h11
    } msg_idx_t;

    typedef struct packed {
        logic signed [CODE_W-1:0] code;
        msg_idx_t                 msg;
    } err_entry_t;

    // Facts about the current command as seen by the parser and executor.
    typedef struct packed {
        logic             valid;
        logic [LEN_W-1:0] header_len;
        logic [LEN_W-1:0] suffix_len;
        logic [LEN_W-1:0] string_len;
        logic             string_limited;
        logic [LEN_W-1:0] mantissa_digits;
        logic             params_extra;
        logic             params_missing;
        logic             get_mid_string;
        logic             trigger;
        logic             initiate;
        logic             read_query;
        logic             limits_set;
        logic             lower_gt_upper;
        logic             fetch_remove;
        logic             data_cmd;
        logic             out_overflow;
        logic             idn_not_last;
    } cmd_info_t;

    // Instrument state relevant to error detection.
    typedef struct packed {
        logic scan_running;
        logic trig_src_bus;
        logic reading_mem_empty;
        logic out_buf_full;
        logic in_buf_full;
        logic talk_addressed;
    } inst_state_t;

    typedef enum logic [1:0] {
        BEEP_IDLE = 2'b00,
        BEEP_ON   = 2'b01
    } beep_state_t;

endpackage

// File: err_detect.sv
// Error detector: turns one command's facts into accept/reject verdicts and error events.
// Assumes cmd is a one-cycle valid pulse with its facts stable in that cycle.
`timescale 1ns/1ps
module err_detect
    import err_queue_pkg::*;
(
    // Command facts
    input  wire cmd_info_t          cmd,
    input  wire inst_state_t        st,
    // Verdicts
    output logic                    reject,
    output logic                    discard_out,
    output logic                    stale_flag,
    output logic                    talk_no_data,
    // Error events
    output logic [EVT_N-1:0]        evt
);

    wire hdr_long    = cmd.header_len > LEN_W'(HEADER_MAX);
    wire suffix_long = cmd.suffix_len > LEN_W'(SUFFIX_MAX);
    wire str_long    = cmd.string_limited && (cmd.string_len > LEN_W'(STRING_MAX));
    wire digits_long = cmd.mantissa_digits > LEN_W'(MANTISSA_MAX);
    wire trig_ign    = cmd.trigger && st.scan_running;
    wire init_ign    = cmd.initiate && st.scan_running;
    wire trig_dead   = cmd.read_query && st.trig_src_bus;
    wire limits_bad  = cmd.limits_set && cmd.lower_gt_upper;
    wire stale       = cmd.fetch_remove && st.reading_mem_empty;
    wire q_intr      = cmd.data_cmd && st.out_buf_full;
    wire q_dead      = cmd.out_overflow && st.in_buf_full;

    // Event order matches the message table order, lowest index first.
    assign evt[0]  = cmd.valid && cmd.get_mid_string;
    assign evt[1]  = cmd.valid && cmd.params_extra;
    assign evt[2]  = cmd.valid && cmd.params_missing;
    assign evt[3]  = cmd.valid && hdr_long;
    assign evt[4]  = cmd.valid && digits_long;
    assign evt[5]  = cmd.valid && suffix_long;
    assign evt[6]  = cmd.valid && trig_ign;
    assign evt[7]  = cmd.valid && init_ign;
    assign evt[8]  = cmd.valid && trig_dead;
    assign evt[9]  = cmd.valid && limits_bad;
    assign evt[10] = cmd.valid && str_long;
    assign evt[11] = cmd.valid && stale;
    assign evt[12] = 1'b0;
    assign evt[13] = cmd.valid && q_intr;
    assign evt[14] = st.talk_addressed && !cmd.valid && !st.out_buf_full;
    assign evt[15] = cmd.valid && q_dead;
    assign evt[16] = cmd.valid && cmd.idn_not_last;

    assign reject       = cmd.valid && (cmd.get_mid_string || cmd.params_extra
                          || cmd.params_missing || hdr_long || digits_long || suffix_long
                          || trig_ign || init_ign || limits_bad || str_long || q_intr);
    assign discard_out  = cmd.valid && q_dead;
    assign stale_flag   = cmd.valid && stale;
    assign talk_no_data = evt[14];

endmodule

// File: err_beeper.sv
// Beeper: one fixed-length beep pulse per generated error; retriggers restart it.
// Assumes new_err is a one-cycle pulse per stored or discarded error.
`timescale 1ns/1ps
module err_beeper
    import err_queue_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Event and output
    input  wire logic new_err,
    output logic      beep
);

    beep_state_t     state_q;
    beep_state_t     state_d;
    logic [3:0]      cnt_q;
    logic [3:0]      cnt_d;

    wire cnt_done = cnt_q == 4'(BEEP_CYC - 1);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            BEEP_IDLE: begin
                if (new_err) begin
                    state_d = BEEP_ON;
                    cnt_d   = 4'h0;
                end
            end
            BEEP_ON: begin
                if (new_err) begin
                    cnt_d = 4'h0;
                end else if (cnt_done) begin
                    state_d = BEEP_IDLE;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            default: state_d = BEEP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= BEEP_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign beep = state_q == BEEP_ON;

endmodule

// File: command_error_queue.sv
// Command error queue: detects command errors, queues them oldest first, reports on read.
// Assumes synchronous inputs on sys_clk; host interface logic drives the pulses below.
`timescale 1ns/1ps
module command_error_queue
    import err_queue_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Command facts from the parser and executor
    input  wire cmd_info_t   cmd,
    input  wire inst_state_t st,
    // Common commands
    input  wire logic        clear_status,
    input  wire logic        factory_reset,
    input  wire logic        preset,
    // Error read request
    input  wire logic        err_read,
    // Error read answer
    output logic             rd_valid,
    output err_entry_t       rd_entry,
    // Command verdicts
    output logic             cmd_reject,
    output logic             out_discard,
    output logic             data_stale,
    output logic             talk_suppress,
    // Front panel
    output logic             err_lamp,
    output logic             beep,
    output logic [CNT_W-1:0] err_count
);

    err_entry_t             mem_q [QUEUE_DEPTH];
    logic [PTR_W-1:0]       rd_ptr_q;
    logic [PTR_W-1:0]       wr_ptr_q;
    logic [CNT_W-1:0]       cnt_q;
    logic                   ovf_q;
    logic                   rd_valid_q;
    err_entry_t             rd_entry_q;
    logic [EVT_N-1:0]       evt;
    logic                   cmd_reject_w;
    logic                   out_discard_w;
    logic                   stale_w;
    logic                   talk_w;
    err_entry_t             new_entry;
    logic                   new_err;

    err_detect u_detect (
        .cmd         (cmd),
        .st          (st),
        .reject      (cmd_reject_w),
        .discard_out (out_discard_w),
        .stale_flag  (stale_w),
        .talk_no_data(talk_w),
        .evt         (evt)
    );

    // Codes per event, same order as the detector's event vector.
    function automatic err_entry_t entry_of(input int i);
        err_entry_t e;
        e.code = CODE_NONE;
        e.msg  = MSG_NONE;
        case (i)
            0:  begin e.code = CODE_GET;         e.msg = MSG_GET;         end
            1:  begin e.code = CODE_PARAM_EXTRA; e.msg = MSG_PARAM_EXTRA; end
            2:  begin e.code = CODE_PARAM_MISS;  e.msg = MSG_PARAM_MISS;  end
            3:  begin e.code = CODE_HDR_LONG;    e.msg = MSG_HDR_LONG;    end
            4:  begin e.code = CODE_DIGITS;      e.msg = MSG_DIGITS;      end
            5:  begin e.code = CODE_SUFFIX_LONG; e.msg = MSG_SUFFIX_LONG; end
            6:  begin e.code = CODE_TRIG_IGN;    e.msg = MSG_TRIG_IGN;    end
            7:  begin e.code = CODE_INIT_IGN;    e.msg = MSG_INIT_IGN;    end
            8:  begin e.code = CODE_TRIG_DEAD;   e.msg = MSG_TRIG_DEAD;   end
            9:  begin e.code = CODE_SETTINGS;    e.msg = MSG_SETTINGS;    end
            10: begin e.code = CODE_TOO_MUCH;    e.msg = MSG_TOO_MUCH;    end
            11: begin e.code = CODE_STALE;       e.msg = MSG_STALE;       end
            13: begin e.code = CODE_Q_INTR;      e.msg = MSG_Q_INTR;      end
            14: begin e.code = CODE_Q_UNTERM;    e.msg = MSG_Q_UNTERM;    end
            15: begin e.code = CODE_Q_DEAD;      e.msg = MSG_Q_DEAD;      end
            16: begin e.code = CODE_Q_INDEF;     e.msg = MSG_Q_INDEF;     end
            default: begin e.code = CODE_NONE;   e.msg = MSG_NONE;        end
        endcase
        return e;
    endfunction

    // Only one error is recorded per cycle; the lowest event index wins. A command
    // carrying several faults reports the first, which keeps the queue single-ported.
    always_comb begin
        new_entry = '0;
        for (int i = EVT_N - 1; i >= 0; i--) begin
            if (evt[i]) begin
                new_entry = entry_of(i);
            end
        end
    end

    assign new_err = |evt;

    wire clear_q   = clear_status;
    wire q_empty   = cnt_q == '0;
    wire q_full    = cnt_q == CNT_FULL;
    wire do_read   = err_read && !q_empty && !clear_q;
    // Room freed by a read in the same cycle lets a new error in, except while the overflow mark is set.
    wire do_push   = new_err && !clear_q && (!q_full || do_read) && !ovf_q;
    wire do_ovf    = new_err && !clear_q && q_full && !do_read && !ovf_q;
    wire [PTR_W-1:0] wr_next  = (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 4'h1;
    wire [PTR_W-1:0] rd_next  = (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 4'h1;
    wire [PTR_W-1:0] newest   = (wr_ptr_q == '0) ? PTR_LAST : wr_ptr_q - 4'h1;

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= new_entry;
        end else if (do_ovf) begin
            mem_q[newest] <= '{code: CODE_OVERFLOW, msg: MSG_OVERFLOW};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            cnt_q    <= '0;
            ovf_q    <= 1'b0;
        end else if (clear_q) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            cnt_q    <= '0;
            ovf_q    <= 1'b0;
        end else begin
            if (do_read) begin
                rd_ptr_q <= rd_next;
            end
            if (do_push) begin
                wr_ptr_q <= wr_next;
            end
            cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_read);
            if (do_ovf) begin
                ovf_q <= 1'b1;
            end else if (do_read) begin
                ovf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_valid_q <= 1'b0;
            rd_entry_q <= '0;
        end else begin
            rd_valid_q <= err_read;
            if (err_read) begin
                rd_entry_q <= do_read ? mem_q[rd_ptr_q]
                                      : '{code: CODE_NONE, msg: MSG_NONE};
            end
        end
    end

    err_beeper u_beeper (
        .sys_clk(sys_clk),
        .nrst   (nrst),
        .new_err(new_err),
        .beep   (beep)
    );

    // Text for each message index is held by the formatter outside; it uses
    // code, a comma and the quoted text of at most TEXT_MAX characters.
    assign rd_valid      = rd_valid_q;
    assign rd_entry      = rd_entry_q;
    assign err_lamp      = !q_empty;
    assign err_count     = cnt_q;
    assign cmd_reject    = cmd_reject_w;
    assign out_discard   = out_discard_w;
    assign data_stale    = stale_w;
    assign talk_suppress = talk_w;

    property p_fifo_order;
        @(posedge sys_clk) disable iff (!nrst)
        do_read |=> rd_entry.code == $past(mem_q[rd_ptr_q].code);
    endproperty
    a_fifo_order: assert property (p_fifo_order) else $error("Read not oldest.");

    property p_lamp_off;
        @(posedge sys_clk) disable iff (!nrst)
        (cnt_q == 4'h1 && do_read && !do_push) |=> !err_lamp;
    endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("Lamp stayed on.");

    property p_beep;
        @(posedge sys_clk) disable iff (!nrst)
        new_err |=> beep;
    endproperty
    a_beep: assert property (p_beep) else $error("No beep on error.");

    property p_overflow;
        @(posedge sys_clk) disable iff (!nrst)
        do_ovf |=> ovf_q && cnt_q == CNT_FULL && mem_q[$past(newest)].code == CODE_OVERFLOW;
    endproperty
    a_overflow: assert property (p_overflow) else $error("Overflow not marked.");

    property p_empty_read;
        @(posedge sys_clk) disable iff (!nrst)
        (err_read && q_empty) |=> rd_valid && rd_entry.code == CODE_NONE;
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("Empty read wrong.");

    property p_clear;
        @(posedge sys_clk) disable iff (!nrst)
        clear_status |=> cnt_q == '0 && !err_lamp;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not empty.");

    property p_keep_on_reset;
        @(posedge sys_clk) disable iff (!nrst)
        ((factory_reset || preset) && !clear_status && !err_read && !new_err)
            |=> cnt_q == $past(cnt_q);
    endproperty
    a_keep_on_reset: assert property (p_keep_on_reset) else $error("Queue lost.");

    property p_hdr_long;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd.valid && cmd.header_len > LEN_W'(HEADER_MAX)) |-> cmd_reject && evt[3];
    endproperty
    a_hdr_long: assert property (p_hdr_long) else $error("Long header accepted.");

    property p_push_count;
        @(posedge sys_clk) disable iff (!nrst)
        (do_push && !do_read && !clear_q) |=> cnt_q == $past(cnt_q) + 4'h1;
    endproperty
    a_push_count: assert property (p_push_count) else $error("Push lost.");

    property p_lamp_on;
        @(posedge sys_clk) disable iff (!nrst)
        do_push |=> err_lamp;
    endproperty
    a_lamp_on: assert property (p_lamp_on) else $error("Lamp off after error.");

    property p_pop_count;
        @(posedge sys_clk) disable iff (!nrst)
        (do_read && !do_push) |=> cnt_q == $past(cnt_q) - 4'h1;
    endproperty
    a_pop_count: assert property (p_pop_count) else $error("Read did not remove.");

    property p_count_max;
        @(posedge sys_clk) disable iff (!nrst)
        cnt_q <= CNT_FULL;
    endproperty
    a_count_max: assert property (p_count_max) else $error("Queue over ten.");

    property p_ovf_hold;
        @(posedge sys_clk) disable iff (!nrst)
        (ovf_q && !do_read && !clear_q) |=> ovf_q && cnt_q == $past(cnt_q);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("Overflow mark lost.");

    property p_ovf_discard;
        @(posedge sys_clk) disable iff (!nrst)
        (ovf_q && new_err && !clear_q) |=> wr_ptr_q == $past(wr_ptr_q);
    endproperty
    a_ovf_discard: assert property (p_ovf_discard) else $error("Stored in overflow.");

    property p_push_entry;
        @(posedge sys_clk) disable iff (!nrst)
        do_push |=> mem_q[$past(wr_ptr_q)] == $past(new_entry);
    endproperty
    a_push_entry: assert property (p_push_entry) else $error("Entry not stored.");

    property p_read_valid;
        @(posedge sys_clk) disable iff (!nrst)
        err_read |=> rd_valid;
    endproperty
    a_read_valid: assert property (p_read_valid) else $error("Read not answered.");

    property p_entry_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !err_read |=> $stable(rd_entry);
    endproperty
    a_entry_hold: assert property (p_entry_hold) else $error("Answer changed.");

    property p_beep_len;
        @(posedge sys_clk) disable iff (!nrst)
        new_err |=> beep [*3];
    endproperty
    a_beep_len: assert property (p_beep_len) else $error("Beep too short.");

    property p_beep_end;
        @(posedge sys_clk) disable iff (!nrst)
        (!new_err) [*3] |=> !beep;
    endproperty
    a_beep_end: assert property (p_beep_end) else $error("Beep did not end.");

    property p_suffix_long;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd.valid && cmd.suffix_len > LEN_W'(SUFFIX_MAX)) |-> cmd_reject && new_err;
    endproperty
    a_suffix_long: assert property (p_suffix_long) else $error("Long suffix run.");

    property p_str_long;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd.valid && cmd.string_limited && cmd.string_len > LEN_W'(STRING_MAX)) |-> cmd_reject;
    endproperty
    a_str_long: assert property (p_str_long) else $error("Long string run.");

    property p_init_busy;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd.valid && cmd.initiate && st.scan_running) |-> cmd_reject && new_err;
    endproperty
    a_init_busy: assert property (p_init_busy) else $error("Initiate run in scan.");

    property p_stale;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd.valid && cmd.fetch_remove && st.reading_mem_empty) |-> data_stale && new_err;
    endproperty
    a_stale: assert property (p_stale) else $error("Stale data not flagged.");

    property p_discard;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd.valid && cmd.out_overflow && st.in_buf_full) |-> out_discard && new_err;
    endproperty
    a_discard: assert property (p_discard) else $error("Output not dropped.");

    property p_talk;
        @(posedge sys_clk) disable iff (!nrst)
        (st.talk_addressed && !cmd.valid && !st.out_buf_full) |-> talk_suppress && new_err;
    endproperty
    a_talk: assert property (p_talk) else $error("Talk without data missed.");

endmodule

// File: host_model.sv
// Host controller model: sends command facts, clear-status and error read requests.
// Assumes the device answers a read one cycle after the request is taken.
`timescale 1ns/1ps
module host_model
    import err_queue_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Answers from the device
    input  wire logic        rd_valid,
    input  wire err_entry_t  rd_entry,
    input  wire logic [3:0]  verdict,
    // Requests
    output cmd_info_t        cmd,
    output inst_state_t      st,
    output logic             clear_status,
    output logic             err_read
);
    initial begin
        cmd = '0;
        st = '0;
        clear_status = 1'b0;
        err_read = 1'b0;
    end

    // Identification query is sent last unless a test asks for the fault.
    task automatic send(input cmd_info_t c, input inst_state_t s, output logic [3:0] v);
        @(posedge sys_clk);
        cmd <= c;
        st  <= s;
        #1;
        v = verdict;
        @(posedge sys_clk);
        cmd <= '0;
        st  <= '0;
    endtask

    task automatic read(output err_entry_t e, output logic v);
        @(posedge sys_clk);
        err_read <= 1'b1;
        @(posedge sys_clk);
        err_read <= 1'b0;
        #1;
        v = rd_valid;
        e = rd_entry;
    endtask

    task automatic clear();
        @(posedge sys_clk);
        clear_status <= 1'b1;
        @(posedge sys_clk);
        clear_status <= 1'b0;
    endtask
endmodule

// File: command_error_queue_bench.sv
// Self-checking bench for the command error queue with a host model on the far side.
// Assumes a 25 MHz clock and a queue model kept in a bench-side list.
`timescale 1ns/1ps
module command_error_queue_bench;
    import err_queue_pkg::*;
    logic sys_clk, nrst, factory_reset, preset, rd_valid, cmd_reject, out_discard;
    logic data_stale, talk_suppress, err_lamp, beep, clear_status, err_read, ovf;
    logic [CNT_W-1:0] q_count;
    logic [31:0]      seed = 32'hDEA9796C;
    cmd_info_t        cmd;
    inst_state_t      st;
    err_entry_t       rd_entry;
    err_entry_t       exp_q[$];
    int               err_count = 0;
    int               n_tests = 0;
    err_entry_t tbl[16] = '{'{CODE_HDR_LONG, MSG_HDR_LONG}, '{CODE_SUFFIX_LONG, MSG_SUFFIX_LONG},
        '{CODE_DIGITS, MSG_DIGITS}, '{CODE_PARAM_EXTRA, MSG_PARAM_EXTRA},
        '{CODE_PARAM_MISS, MSG_PARAM_MISS}, '{CODE_TOO_MUCH, MSG_TOO_MUCH},
        '{CODE_SETTINGS, MSG_SETTINGS}, '{CODE_GET, MSG_GET}, '{CODE_TRIG_IGN, MSG_TRIG_IGN},
        '{CODE_INIT_IGN, MSG_INIT_IGN}, '{CODE_TRIG_DEAD, MSG_TRIG_DEAD},
        '{CODE_STALE, MSG_STALE}, '{CODE_Q_INTR, MSG_Q_INTR}, '{CODE_Q_DEAD, MSG_Q_DEAD},
        '{CODE_Q_INDEF, MSG_Q_INDEF}, '{CODE_Q_UNTERM, MSG_Q_UNTERM}};

    command_error_queue DUT (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd), .st(st),
        .clear_status(clear_status), .factory_reset(factory_reset), .preset(preset),
        .err_read(err_read), .rd_valid(rd_valid), .rd_entry(rd_entry),
        .cmd_reject(cmd_reject), .out_discard(out_discard), .data_stale(data_stale),
        .talk_suppress(talk_suppress), .err_lamp(err_lamp), .beep(beep),
        .err_count(q_count));
    host_model h (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_entry(rd_entry),
        .verdict({cmd_reject, out_discard, data_stale, talk_suppress}), .cmd(cmd), .st(st),
        .clear_status(clear_status), .err_read(err_read));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Kind k sets exactly one fault; other lengths stay legal so no second error appears.
    function automatic void mk(input int k, output cmd_info_t c, output inst_state_t s);
        c = '0;
        s = '0;
        c.valid = 1'b1;
        c.header_len = 9'(xs() % 13);
        c.suffix_len = 9'(xs() % 13);
        c.mantissa_digits = 9'(xs() % 256);
        case (k)
            0: c.header_len = 9'h00D;
            1: c.suffix_len = 9'h00D;
            2: c.mantissa_digits = 9'h100;
            3: c.params_extra = 1'b1;
            4: c.params_missing = 1'b1;
            5: {c.string_limited, c.string_len} = {1'b1, 9'h00D};
            6: {c.limits_set, c.lower_gt_upper} = 2'b11;
            7: c.get_mid_string = 1'b1;
            8: {c.trigger, s.scan_running} = 2'b11;
            9: {c.initiate, s.scan_running} = 2'b11;
            10: {c.read_query, s.trig_src_bus} = 2'b11;
            11: {c.fetch_remove, s.reading_mem_empty} = 2'b11;
            12: {c.data_cmd, s.out_buf_full} = 2'b11;
            13: {c.out_overflow, s.in_buf_full} = 2'b11;
            14: c.idn_not_last = 1'b1;
            default: {c.valid, s.talk_addressed} = 2'b01;
        endcase
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic push(input int k);
        cmd_info_t c;
        inst_state_t s;
        logic [3:0] v;
        mk(k, c, s);
        h.send(c, s, v);
        if (ovf) ;
        else if (exp_q.size() == QUEUE_DEPTH) begin
            exp_q[$] = '{CODE_OVERFLOW, MSG_OVERFLOW};
            ovf = 1'b1;
        end else exp_q.push_back(tbl[k]);
        #1;
        check(beep, 1, "beep");
        check(q_count, exp_q.size(), "count");
        check(v[3], k inside {[0:9], 12}, "reject");
        if (k == 11) check(v[1], 1, "stale flag");
        if (k == 13) check(v[2], 1, "discard");
        if (k == 15) check(v[0], 1, "talk suppress");
    endtask

    task automatic pull();
        err_entry_t e;
        err_entry_t x;
        logic v;
        x = '{CODE_NONE, MSG_NONE};
        h.read(e, v);
        ovf = 1'b0;
        if (exp_q.size() != 0) x = exp_q.pop_front();
        check(v, 1, "read valid");
        check(e, x, "entry");
        check(err_lamp, exp_q.size() != 0, "lamp");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (6000) @(posedge sys_clk);
        err_count++;
        $display("unexpected at %0t: run did not finish", $time);
        results();
    end

    initial begin
        nrst = 1'b0;
        factory_reset = 1'b0;
        preset = 1'b0;
        ovf = 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            push(k);
            pull();
        end
        $display("test every error kind done");
        for (int i = 0; i < 12; i++) push(xs() % 16);
        for (int i = 0; i < 11; i++) pull();
        $display("test overflow done");
        for (int i = 0; i < 3; i++) push(xs() % 16);
        @(posedge sys_clk);
        factory_reset <= 1'b1;
        preset <= 1'b1;
        @(posedge sys_clk);
        factory_reset <= 1'b0;
        preset <= 1'b0;
        #1;
        check(q_count, 3, "count kept");
        h.clear();
        exp_q.delete();
        #1;
        check(q_count, 0, "count cleared");
        pull();
        $display("test clear done");
        results();
    end
endmodule
